// *** hdl/csp_lfsr.sv ***
// csp_lfsr: free-running random byte source for identifier generation
// assumes nothing beyond the system clock; advances eight steps a cycle
`timescale 1ns/100ps
`default_nettype none
module csp_lfsr (
  input  wire logic       clk,
  input  wire logic       rst_b,
  output logic      [7:0] rnd
);
  import csp_pkg::*;

  typedef struct packed {
    logic [15:0] sr;
  } csp_lfsr_t;

  csp_lfsr_t r_reg;
  csp_lfsr_t r_next;

  always_comb begin
    r_next = r_reg;
    for (int i = 0; i < 8; i++) begin
      if (r_next.sr[0])
        r_next.sr = (r_next.sr >> 1) ^ LFSR_TAPS;
      else
        r_next.sr = r_next.sr >> 1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b)
      r_reg <= '{sr: LFSR_SEED};
    else
      r_reg <= r_next;
  end

  assign rnd = r_reg.sr[7:0];

endmodule
`default_nettype wire

// *** hdl/csp_rstfilt.sv ***
// csp_rstfilt: synchroniser and spike filter of the reset/power-down pin
// assumes the pin is asynchronous to CLK_SYS; output high means power-down
`timescale 1ns/100ps
`default_nettype none
module csp_rstfilt (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic pin_b,
  output logic      pd
);
  import csp_pkg::*;

  typedef struct packed {
    logic       s1;
    logic       s2;
    logic       s3;
    logic [1:0] cnt;
    logic       pd;
  } csp_rf_t;

  csp_rf_t r_reg;
  csp_rf_t r_next;

  always_comb begin
    r_next = r_reg;
    r_next.s1 = pin_b;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    // short pulses never outlast the count and are dropped
    if (r_reg.s2 == r_reg.s3 && r_reg.s3 == r_reg.pd) begin
      if (r_reg.cnt == 2'(SPIKE_CYC - 1)) begin
        r_next.pd  = ~r_reg.s3;
        r_next.cnt = 2'h0;
      end else begin
        r_next.cnt = r_reg.cnt + 2'h1;
      end
    end else begin
      r_next.cnt = 2'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b)
      r_reg <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, cnt: 2'h0, pd: 1'b0};
    else
      r_reg <= r_next;
  end

  assign pd = r_reg.pd;

endmodule
`default_nettype wire

// *** hdl/csp_top.sv ***
// csp_top: command sequencer, fifo, configuration buffer, power control
// assumes a classic wishbone master on CLK_SYS and datapaths on CLK_SYS
// Function
// - reset pin low freezes state, stops clock and bus answer
// - sleep bit set enters soft power-down
// - soft power-down keeps registers, fifo, configuration
// - sleep bit reads one 1024 clocks after clear
// - either driver enable cleared stops field, in soft power-down only at its exit
// - reset spikes ignored, hold low for three consecutive clock samples
// - 1024 clock startup delay before host access
// - command code starts, data via fifo only
// - decoder uses the documented 4-bit codes
// - stream commands start at once, except send-listen
// - fixed-argument command waits for full argument count
// - command start never flushes the fifo, except soft reset
// - new command code aborts running command
// - hold code changes only other command bits
// - idle cancels activity and ends itself
// - configure loads 25 bytes into buffer
// - first identifier byte fixed, check byte computed
// - ten-byte identifier built from buffer bytes
// - configure on empty fifo reads buffer back
// - configuration survives hard power-down
// - configure ends itself back to idle
// - random id overwrites nine buffer bytes, ends
// - return to idle sets idle event flag
// - software reset clears registers, keeps buffer
`timescale 1ns/100ps
`default_nettype none
module csp_top (
  input  wire logic                 CLK_SYS,
  input  wire logic                 RST_B,
  input  wire logic                 RESET_SLEEP_REQUEST_BIT_PIN_B,
  input  wire csp_pkg::csp_wb_req_t WB_I,
  output logic                      WB_ACK_O,
  output logic [csp_pkg::DAT_W-1:0] WB_DAT_O,
  input  wire logic                 DP_DONE,
  output logic                      DP_START,
  output csp_pkg::csp_cmd_t         DP_CMD,
  output logic                      ANT_FIELD_ON,
  output logic                      OSC_RUN
);
  import csp_pkg::*;

  typedef struct packed {
    logic                           ack;
    logic [DAT_W-1:0]               rdat;
    csp_cmd_t                       cmd;
    csp_phase_t                     phase;
    logic [IDX_W-1:0]               idx;
    logic                           sleep;
    logic                           pd_soft;
    logic [CNT_W-1:0]               exit_cnt;
    logic [CNT_W-1:0]               boot_cnt;
    logic                           hard_pd;
    logic [1:0]                     drv_en;
    logic                           trigger;
    logic                           idle_flag;
    logic [3:0]                     id3_sel;
    logic [FIFO_DEPTH-1:0][7:0]     fifo;
    logic [PTR_W-1:0]               wp;
    logic [PTR_W-1:0]               rp;
    logic [LVL_W-1:0]               lvl;
    logic [CFG_BYTES-1:0][7:0]      cfg;
    logic                           dp_start;
    logic                           field;
    logic                           osc;
  } csp_top_t;

  csp_top_t   r_reg;
  csp_top_t   r_next;
  logic       pin_pd;
  logic [7:0] rnd;

  csp_rstfilt u_rstfilt (
    .clk   (CLK_SYS),
    .rst_b (RST_B),
    .pin_b (RESET_SLEEP_REQUEST_BIT_PIN_B),
    .pd    (pin_pd)
  );

  csp_lfsr u_lfsr (
    .clk   (CLK_SYS),
    .rst_b (RST_B),
    .rnd   (rnd)
  );

  // register defaults; the configuration buffer is passed through
  function automatic csp_top_t rst_val(
    input logic [CFG_BYTES-1:0][7:0] cfg);
    rst_val          = '0;
    rst_val.cmd      = CMD_IDLE;
    rst_val.phase    = PH_IDLE;
    rst_val.drv_en   = DRV_CTRL_RST;
    rst_val.boot_cnt = STARTUP_CLKS;
    rst_val.osc      = 1'b1;
    rst_val.cfg      = cfg;
  endfunction

  function automatic logic known_cmd(input logic [3:0] c);
    case (c)
      CMD_IDLE, CMD_CONFIG, CMD_RANDOM_ID, CMD_CHECKSUM, CMD_TRANSMIT,
      CMD_HOLD, CMD_RECEIVE, CMD_SEND_LISTEN, CMD_AUTO_ACT,
      CMD_SOFT_RESET: known_cmd = 1'b1;
      default:        known_cmd = 1'b0;
    endcase
  endfunction

  always_comb begin
    logic       do_push;
    logic       do_pop;
    logic       push_ok;
    logic       pop_ok;
    logic       flush;
    logic       soft_rst;
    logic       finish;
    logic [7:0] push_data;
    logic [7:0] pop_data;
    logic [7:0] rb;
    logic [3:0] code;
    do_push   = 1'b0;
    do_pop    = 1'b0;
    push_ok   = 1'b0;
    pop_ok    = 1'b0;
    flush     = 1'b0;
    soft_rst  = 1'b0;
    finish    = 1'b0;
    push_data = 8'h00;
    pop_data  = r_reg.fifo[r_reg.rp];
    rb        = 8'h00;
    code      = WB_I.dat[3:0];
    r_next    = r_reg;
    r_next.dp_start = 1'b0;
    r_next.ack      = 1'b0;

    if (pin_pd) begin
      // whole state held; only the bus handshake, start pulse and clock are dropped
      r_next.hard_pd = 1'b1;
      r_next.osc     = 1'b0;
    end else if (r_reg.hard_pd) begin
      r_next = rst_val(r_reg.cfg);
    end else begin
      if (r_reg.boot_cnt != '0)
        r_next.boot_cnt = r_reg.boot_cnt - CNT_W'(1);

      if (r_reg.exit_cnt != '0) begin
        r_next.exit_cnt = r_reg.exit_cnt - CNT_W'(1);
        if (r_reg.exit_cnt == CNT_W'(1)) begin
          r_next.sleep   = 1'b0;
          r_next.pd_soft = 1'b0;
        end
      end

      // bus slave; no answer at all until the startup delay has run out
      if (WB_I.cyc && WB_I.stb && !r_reg.ack && r_reg.boot_cnt == '0) begin
        r_next.ack = 1'b1;
        if (WB_I.we && WB_I.sel[0]) begin
          unique case (WB_I.adr)
            OFS_COMMAND: begin
              if (WB_I.dat[CMD_SLEEP_BIT]) begin
                r_next.sleep    = 1'b1;
                r_next.pd_soft  = 1'b1;
                r_next.exit_cnt = '0;
              end else if (r_reg.sleep && r_reg.exit_cnt == '0) begin
                r_next.exit_cnt = EXIT_CLKS;
              end
              // undefined codes leave the running command alone
              if (code != CMD_HOLD && known_cmd(code)) begin
                r_next.cmd   = csp_cmd_t'(code);
                r_next.phase = PH_IDLE;
                r_next.idx   = '0;
                unique case (csp_cmd_t'(code))
                  CMD_IDLE:       r_next.idle_flag = 1'b1;
                  CMD_SOFT_RESET: soft_rst = 1'b1;
                  CMD_CONFIG: begin
                    if (r_reg.lvl == '0)
                      r_next.phase = PH_READBACK;
                    else
                      r_next.phase = PH_WAIT_ARG;
                  end
                  CMD_RANDOM_ID:  r_next.phase = PH_RANDOM;
                  CMD_SEND_LISTEN: r_next.phase = PH_RUN;
                  default: begin
                    // fifo left as loaded by the host
                    r_next.phase    = PH_RUN;
                    r_next.dp_start = 1'b1;
                  end
                endcase
              end
            end
            OFS_FIFO_DATA: begin
              do_push   = 1'b1;
              push_data = WB_I.dat[7:0];
            end
            OFS_FIFO_LEVEL:  flush = WB_I.dat[LVL_FLUSH_BIT];
            OFS_COM_IRQ: begin
              if (WB_I.dat[IRQ_IDLE_BIT])
                r_next.idle_flag = 1'b0;
            end
            OFS_DRIVER_CTRL: begin
              r_next.drv_en[DRV_ONE_BIT] = WB_I.dat[DRV_ONE_BIT];
              r_next.drv_en[DRV_TWO_BIT] = WB_I.dat[DRV_TWO_BIT];
            end
            OFS_BIT_FRAMING: r_next.trigger = WB_I.dat[FRM_TRIGGER_BIT];
            OFS_ID3_SEL:     r_next.id3_sel = WB_I.dat[3:0];
            default: ;
          endcase
        end else if (!WB_I.we) begin
          unique case (WB_I.adr)
            OFS_COMMAND: begin
              rb[3:0]           = r_reg.cmd;
              rb[CMD_SLEEP_BIT] = r_reg.sleep;
            end
            OFS_FIFO_DATA: begin
              rb     = (r_reg.lvl != '0) ? pop_data : 8'h00;
              do_pop = 1'b1;
            end
            OFS_FIFO_LEVEL: rb = 8'(r_reg.lvl);
            OFS_COM_IRQ:    rb[IRQ_IDLE_BIT] = r_reg.idle_flag;
            OFS_DRIVER_CTRL: rb[1:0] = r_reg.drv_en;
            OFS_BIT_FRAMING: rb[FRM_TRIGGER_BIT] = r_reg.trigger;
            OFS_STATUS: begin
              rb[ST_SOFT_PD_BIT] = r_reg.pd_soft;
              rb[ST_EXITING_BIT] = (r_reg.exit_cnt != '0);
              rb[ST_FIELD_BIT]   = r_reg.field;
              rb[ST_BUSY_BIT]    = (r_reg.phase != PH_IDLE);
            end
            OFS_ID3_SEL:  rb[3:0] = r_reg.id3_sel;
            OFS_ID3_DATA: rb = r_reg.cfg[id3_slot(r_reg.id3_sel)];
            OFS_CHECK_BYTE: begin
              rb = CASCADE_TAG ^ r_reg.cfg[NFCID1_POS]
                 ^ r_reg.cfg[NFCID1_POS + 1] ^ r_reg.cfg[NFCID1_POS + 2];
            end
            default: ;
          endcase
        end
        r_next.rdat = {24'h000000, rb};
      end

      // sequencer; frozen while the oscillator is off
      if (!r_reg.pd_soft) begin
        unique case (r_reg.phase)
          PH_IDLE: ;
          PH_WAIT_ARG: begin
            if (r_reg.lvl >= LVL_W'(CFG_BYTES))
              r_next.phase = PH_LOAD;
          end
          PH_LOAD: begin
            do_pop = 1'b1;
            if (r_reg.idx == IDX_W'(NFCID1_POS))
              r_next.cfg[r_reg.idx] = NFCID1_FIXED;
            else
              r_next.cfg[r_reg.idx] = pop_data;
            r_next.idx = r_reg.idx + IDX_W'(1);
            finish = (r_reg.idx == IDX_W'(CFG_BYTES - 1));
          end
          PH_READBACK: begin
            do_push    = 1'b1;
            push_data  = r_reg.cfg[r_reg.idx];
            r_next.idx = r_reg.idx + IDX_W'(1);
            finish = (r_reg.idx == IDX_W'(CFG_BYTES - 1));
          end
          PH_RANDOM: begin
            // fixed leading identifier byte is never replaced
            if (id3_slot(r_reg.idx[3:0]) != IDX_W'(NFCID1_POS))
              r_next.cfg[id3_slot(r_reg.idx[3:0])] = rnd;
            r_next.idx = r_reg.idx + IDX_W'(1);
            finish = (r_reg.idx == IDX_W'(ID3_BYTES - 1));
          end
          PH_RUN: begin
            if (r_reg.cmd == CMD_SEND_LISTEN && r_reg.trigger) begin
              r_next.dp_start = 1'b1;
              r_next.trigger  = 1'b0;
            end
            if (DP_DONE) begin
              unique case (r_reg.cmd)
                CMD_TRANSMIT, CMD_RECEIVE: finish = 1'b1;
                CMD_AUTO_ACT: r_next.cmd = CMD_SEND_LISTEN;
                default: ;
              endcase
            end
          end
          default: r_next.phase = PH_IDLE;
        endcase
      end

      if (finish) begin
        r_next.cmd       = CMD_IDLE;
        r_next.phase     = PH_IDLE;
        r_next.idle_flag = 1'b1;
      end

      // fifo update; sequencer access takes the slot over the bus
      push_ok = do_push && r_reg.lvl != LVL_W'(FIFO_DEPTH);
      pop_ok  = do_pop && r_reg.lvl != '0;
      if (flush) begin
        r_next.wp  = '0;
        r_next.rp  = '0;
        r_next.lvl = '0;
      end else begin
        if (push_ok) begin
          r_next.fifo[r_reg.wp] = push_data;
          r_next.wp = r_reg.wp + PTR_W'(1);
        end
        if (pop_ok)
          r_next.rp = r_reg.rp + PTR_W'(1);
        unique case ({push_ok, pop_ok})
          2'b10:   r_next.lvl = r_reg.lvl + LVL_W'(1);
          2'b01:   r_next.lvl = r_reg.lvl - LVL_W'(1);
          default: r_next.lvl = r_reg.lvl;
        endcase
      end

      // field output keeps its level through soft power-down; oscillator stops
      if (!r_next.pd_soft)
        r_next.field = &r_next.drv_en;
      r_next.osc = !r_next.pd_soft;

      if (soft_rst) begin
        r_next           = rst_val(r_reg.cfg);
        r_next.boot_cnt  = '0;
        r_next.ack       = 1'b1;
        r_next.idle_flag = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B)
      r_reg <= rst_val('0);
    else
      r_reg <= r_next;
  end

  assign WB_ACK_O     = r_reg.ack;
  assign WB_DAT_O     = r_reg.rdat;
  assign DP_START     = r_reg.dp_start;
  assign DP_CMD       = r_reg.cmd;
  assign ANT_FIELD_ON = r_reg.field;
  assign OSC_RUN      = r_reg.osc;

endmodule
`default_nettype wire

// *** inc/csp_pkg.sv ***
// csp_pkg: constants, command codes and carriers of the command sequencer
// assumes a 125 MHz system clock and a 32-bit classic wishbone register bus
package csp_pkg;

  localparam int ADR_W = 8;
  localparam int DAT_W = 32;

  // register byte offsets
  localparam logic [ADR_W-1:0] OFS_COMMAND     = 8'h00;
  localparam logic [ADR_W-1:0] OFS_FIFO_DATA   = 8'h04;
  localparam logic [ADR_W-1:0] OFS_FIFO_LEVEL  = 8'h08;
  localparam logic [ADR_W-1:0] OFS_COM_IRQ     = 8'h0C;
  localparam logic [ADR_W-1:0] OFS_DRIVER_CTRL = 8'h10;
  localparam logic [ADR_W-1:0] OFS_BIT_FRAMING = 8'h14;
  localparam logic [ADR_W-1:0] OFS_STATUS      = 8'h18;
  localparam logic [ADR_W-1:0] OFS_ID3_SEL     = 8'h1C;
  localparam logic [ADR_W-1:0] OFS_ID3_DATA    = 8'h20;
  localparam logic [ADR_W-1:0] OFS_CHECK_BYTE  = 8'h24;

  // field positions
  localparam int CMD_SLEEP_BIT   = 4;
  localparam int LVL_FLUSH_BIT   = 7;
  localparam int IRQ_IDLE_BIT    = 4;
  localparam int DRV_ONE_BIT     = 0;
  localparam int DRV_TWO_BIT     = 1;
  localparam int FRM_TRIGGER_BIT = 7;
  localparam int ST_SOFT_PD_BIT  = 0;
  localparam int ST_EXITING_BIT  = 1;
  localparam int ST_FIELD_BIT    = 2;
  localparam int ST_BUSY_BIT     = 3;

  // fifo and configuration buffer
  localparam int FIFO_DEPTH = 64;
  localparam int PTR_W      = 6;
  localparam int LVL_W      = 7;
  localparam int CFG_BYTES  = 25;
  localparam int IDX_W      = 5;
  localparam int ID3_BYTES  = 10;
  localparam int NFCID1_POS = 2;
  localparam int NFCID2_POS = 8;
  localparam int NFCID3_POS = 24;
  localparam int NFCID1_LEN = 3;
  localparam int NFCID2_LEN = 6;
  localparam logic [7:0] NFCID1_FIXED = 8'h08;
  localparam logic [7:0] CASCADE_TAG  = 8'h88;
  localparam logic [1:0] DRV_CTRL_RST = 2'h0;

  // timing
  localparam int CNT_W = 11;
  localparam logic [CNT_W-1:0] EXIT_CLKS    = 11'h400;
  localparam logic [CNT_W-1:0] STARTUP_CLKS = 11'h400;
  localparam int CLK_NS   = 8;
  localparam int SPIKE_NS = 10;
  localparam int SPIKE_CYC = (SPIKE_NS + CLK_NS - 1) / CLK_NS;

  // random generator; seed value is arbitrary
  localparam logic [15:0] LFSR_SEED = 16'h5A3C;
  localparam logic [15:0] LFSR_TAPS = 16'hB400;

  typedef enum logic [3:0] {
    CMD_IDLE        = 4'h0,
    CMD_CONFIG      = 4'h1,
    CMD_RANDOM_ID   = 4'h2,
    CMD_CHECKSUM    = 4'h3,
    CMD_TRANSMIT    = 4'h4,
    CMD_HOLD        = 4'h7,
    CMD_RECEIVE     = 4'h8,
    CMD_SEND_LISTEN = 4'hC,
    CMD_AUTO_ACT    = 4'hD,
    CMD_SOFT_RESET  = 4'hF
  } csp_cmd_t;

  typedef enum logic [2:0] {
    PH_IDLE     = 3'h0,
    PH_WAIT_ARG = 3'h1,
    PH_LOAD     = 3'h2,
    PH_READBACK = 3'h3,
    PH_RANDOM   = 3'h4,
    PH_RUN      = 3'h5
  } csp_phase_t;

  typedef struct packed {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [ADR_W-1:0] adr;
    logic [3:0]       sel;
    logic [DAT_W-1:0] dat;
  } csp_wb_req_t;

  // byte of the 10-byte identifier to its slot in the configuration buffer
  function automatic logic [IDX_W-1:0] id3_slot(input logic [3:0] i);
    if (i < 4'(NFCID1_LEN))
      id3_slot = IDX_W'(NFCID1_POS) + IDX_W'(i);
    else if (i < 4'(NFCID1_LEN + NFCID2_LEN))
      id3_slot = IDX_W'(NFCID2_POS - NFCID1_LEN) + IDX_W'(i);
    else
      id3_slot = IDX_W'(NFCID3_POS);
  endfunction

endpackage

// *** sim/csp_dp_model.sv ***
// csp_dp_model: datapath stand-in that answers started commands
// assumes DP_CMD is valid in the cycle of the start pulse
`timescale 1ns/100ps
`default_nettype none
module csp_dp_model (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              slow,
  input  wire logic              start,
  input  wire csp_pkg::csp_cmd_t cmd,
  output logic                   done,
  output logic [7:0]             starts
);
  import csp_pkg::*;
  logic [5:0] wait_reg;
  // checksum and send-listen never finish on their own
  always_ff @(posedge clk) begin
    done <= 1'b0;
    if (!rst_b) begin
      wait_reg <= 6'h00;
      starts   <= 8'h00;
    end else if (start) begin
      starts <= starts + 8'h01;
      if (cmd inside {CMD_TRANSMIT, CMD_RECEIVE, CMD_AUTO_ACT})
        wait_reg <= slow ? 6'h28 : 6'h02;
    end else if (wait_reg != 6'h00) begin
      wait_reg <= wait_reg - 6'h01;
      done     <= (wait_reg == 6'h01);
    end
  end
endmodule
`default_nettype wire

// *** sim/csp_top_sva.sv ***
// csp_top_sva: port-level assertions of the command sequencer
// assumes it is bound onto csp_top and sees only its ports
`timescale 1ns/100ps
`default_nettype none
module csp_top_sva (
  input wire logic                 CLK_SYS,
  input wire logic                 RST_B,
  input wire logic                 RESET_SLEEP_REQUEST_BIT_PIN_B,
  input wire csp_pkg::csp_wb_req_t WB_I,
  input wire logic                 WB_ACK_O,
  input wire logic [csp_pkg::DAT_W-1:0] WB_DAT_O,
  input wire logic                 DP_DONE,
  input wire logic                 DP_START,
  input wire csp_pkg::csp_cmd_t    DP_CMD,
  input wire logic                 ANT_FIELD_ON,
  input wire logic                 OSC_RUN
);
  import csp_pkg::*;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  logic        wr_ok;
  logic        wr_cmd;
  logic        exiting_reg;
  logic [11:0] exit_cnt_reg;
  logic [11:0] boot_cnt_reg;
  assign wr_ok  = WB_I.cyc && WB_I.stb && WB_I.we && WB_I.sel[0];
  assign wr_cmd = wr_ok && WB_I.adr == OFS_COMMAND;
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      exiting_reg  <= 1'b0;
      exit_cnt_reg <= 12'h000;
      boot_cnt_reg <= 12'h000;
    end else begin
      if (boot_cnt_reg != 12'hFFF)
        boot_cnt_reg <= boot_cnt_reg + 12'h001;
      if (OSC_RUN) begin
        exiting_reg  <= 1'b0;
        exit_cnt_reg <= 12'h000;
      end else if (WB_ACK_O && $past(wr_cmd) && !$past(WB_I.dat[4]))
        exiting_reg <= 1'b1;
      if (exiting_reg)
        exit_cnt_reg <= exit_cnt_reg + 12'h001;
    end
  end
  sequence cmd_ack_s(logic [3:0] c);
    WB_ACK_O && $past(wr_cmd) && $past(WB_I.dat[3:0]) == c;
  endsequence
  ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (WB_ACK_O |->
    $past(WB_I.cyc && WB_I.stb) && WB_DAT_O[31:8] == 24'h0)
    else $error("ack without request or dirty data");
  startup_wait_a: assert property (WB_ACK_O |-> boot_cnt_reg >= 12'h401)
    else $error("access answered during startup delay");
  pin_freeze_a: assert property (!RESET_SLEEP_REQUEST_BIT_PIN_B [*8] |-> !OSC_RUN
    && !WB_ACK_O && $stable(DP_CMD) && $stable(ANT_FIELD_ON))
    else $error("hard power-down not frozen");
  sleep_enter_a: assert property (WB_ACK_O && $past(wr_cmd && WB_I.dat[4])
    |-> ##[0:1] !OSC_RUN) else $error("sleep not entered");
  // counter starts one cycle after the ack of the clearing write
  sleep_exit_a: assert property (exiting_reg && OSC_RUN |->
    exit_cnt_reg == 12'h3FF)
    else $error("soft power-down exit time wrong");
  exit_bound_a: assert property (exiting_reg |-> exit_cnt_reg < 12'h400)
    else $error("soft power-down never left");
  field_off_a: assert property (WB_ACK_O && OSC_RUN && $past(wr_ok &&
    WB_I.adr == OFS_DRIVER_CTRL && WB_I.dat[1:0] != 2'h3) |=> !ANT_FIELD_ON)
    else $error("field on with a driver disabled");
  dp_start_a: assert property (WB_ACK_O && OSC_RUN && $past(wr_cmd) &&
    $past(WB_I.dat[3:0]) inside {4'h3, 4'h4, 4'h8, 4'hD} |-> DP_START)
    else $error("stream command not started at once");
  dp_pulse_a: assert property (DP_START |=> !DP_START)
    else $error("start longer than one cycle");
  hold_code_a: assert property (cmd_ack_s(4'h7) |-> $stable(DP_CMD))
    else $error("hold code changed the command");
  idle_write_a: assert property (cmd_ack_s(4'h0) |-> DP_CMD == CMD_IDLE)
    else $error("idle write did not abort");
  soft_reset_a: assert property (cmd_ack_s(4'hF) |-> ##[0:3]
    DP_CMD == CMD_IDLE && !ANT_FIELD_ON) else $error("soft reset incomplete");
  done_idle_a: assert property (DP_DONE && OSC_RUN && DP_CMD inside
    {CMD_TRANSMIT, CMD_RECEIVE} |=> DP_CMD == CMD_IDLE)
    else $error("finished command not idle");
  auto_next_a: assert property (DP_DONE && OSC_RUN &&
    DP_CMD == CMD_AUTO_ACT |=> DP_CMD == CMD_SEND_LISTEN)
    else $error("activation did not hand over");
endmodule
bind csp_top csp_top_sva u_sva (.CLK_SYS(CLK_SYS), .RST_B(RST_B),
  .RESET_SLEEP_REQUEST_BIT_PIN_B(RESET_SLEEP_REQUEST_BIT_PIN_B), .WB_I(WB_I),
  .WB_ACK_O(WB_ACK_O), .WB_DAT_O(WB_DAT_O), .DP_DONE(DP_DONE),
  .DP_START(DP_START), .DP_CMD(DP_CMD), .ANT_FIELD_ON(ANT_FIELD_ON),
  .OSC_RUN(OSC_RUN));
`default_nettype wire

// *** sim/csp_top_test.sv ***
// csp_top_test: register-level tests of the command sequencer
// assumes csp_top, its checker and the datapath model in the build
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module csp_top_test;
  import csp_pkg::*;
  logic             clk = 1'b0;
  logic             rst_b = 1'b0;
  logic             pin_b = 1'b1;
  logic             slow = 1'b0;
  csp_wb_req_t      wb = '0;
  logic             ack;
  logic [DAT_W-1:0] rdat;
  logic             dp_done;
  logic             dp_start;
  csp_cmd_t         dp_cmd;
  logic             field;
  logic             osc;
  logic [7:0]       starts;
  logic [7:0]       q;
  logic [7:0]       cfg [CFG_BYTES];
  int               errors = 0;
  int               checked = 0;
  int               waited;
  always #4 clk = ~clk;
  csp_top uut (.CLK_SYS(clk), .RST_B(rst_b), .RESET_SLEEP_REQUEST_BIT_PIN_B(pin_b),
    .WB_I(wb), .WB_ACK_O(ack), .WB_DAT_O(rdat), .DP_DONE(dp_done),
    .DP_START(dp_start), .DP_CMD(dp_cmd), .ANT_FIELD_ON(field),
    .OSC_RUN(osc));
  csp_dp_model u_dp (.clk(clk), .rst_b(rst_b), .slow(slow),
    .start(dp_start), .cmd(dp_cmd), .done(dp_done), .starts(starts));
  // waits through startup and power-down instead of assuming a latency
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    waited = 0;
    @(posedge clk);
    wb <= '{1'b1, 1'b1, w, a, 4'h1, {24'h0, d}};
    do begin
      @(posedge clk);
      waited++;
    end while (ack !== 1'b1 && waited < 3000);
    q = rdat[7:0];
    wb <= '0;
    if (waited >= 3000) errors++;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    `CHK(q, e)
  endtask
  task automatic to_idle;
    for (int i = 0; i < 100; i++) begin
      xfer(1'b0, OFS_COMMAND, 8'h00);
      if (q[3:0] == 4'h0) break;
    end
  endtask
  // identifier slots other than the fixed byte at 2 are skipped when all is low
  function automatic logic keep(input int i);
    return i < 3 || (i > 4 && i < 8) || (i > 13 && i < 24);
  endfunction
  task automatic readback(input logic all);
    wr(OFS_FIFO_LEVEL, 8'h80);
    wr(OFS_COMMAND, {4'h0, CMD_CONFIG});
    to_idle();
    rd(OFS_FIFO_LEVEL, 8'h19);
    for (int i = 0; i < CFG_BYTES; i++) begin
      xfer(1'b0, OFS_FIFO_DATA, 8'h00);
      if (all || keep(i)) `CHK(q, cfg[i])
    end
  endtask
  task automatic summarize;
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (25000) @(posedge clk);
    errors++;
    summarize();
  end
  initial begin
    for (int i = 0; i < CFG_BYTES; i++) cfg[i] = 8'h10 + 8'(i);
    cfg[2] = NFCID1_FIXED;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    to_idle();
    `CHK(waited >= 1020, 1'b1)
    rd(OFS_COMMAND, 8'h00);
    rd(OFS_DRIVER_CTRL, 8'(DRV_CTRL_RST));
    rd(8'h30, 8'h00);
    slow <= 1'b1;
    wr(OFS_COMMAND, {4'h0, CMD_TRANSMIT});
    rd(OFS_COMMAND, 8'h04);
    repeat (60) @(posedge clk);
    rd(OFS_COMMAND, 8'h00);
    rd(OFS_COM_IRQ, 8'h10);
    wr(OFS_COM_IRQ, 8'h10);
    rd(OFS_COM_IRQ, 8'h00);
    slow <= 1'b0;
    wr(OFS_COMMAND, {4'h0, CMD_RECEIVE});
    repeat (10) @(posedge clk);
    rd(OFS_COMMAND, 8'h00);
    `CHK(starts, 8'h02)
    wr(OFS_COMMAND, {4'h0, CMD_CHECKSUM});
    wr(OFS_COMMAND, {4'h0, CMD_HOLD});
    rd(OFS_COMMAND, 8'h03);
    wr(OFS_COM_IRQ, 8'h10);
    wr(OFS_COMMAND, {4'h0, CMD_IDLE});
    rd(OFS_COMMAND, 8'h00);
    rd(OFS_COM_IRQ, 8'h10);
    wr(OFS_COMMAND, {4'h0, CMD_AUTO_ACT});
    repeat (10) @(posedge clk);
    rd(OFS_COMMAND, 8'h0C);
    `CHK(starts, 8'h04)
    wr(OFS_BIT_FRAMING, 8'h80);
    repeat (3) @(posedge clk);
    `CHK(starts, 8'h05)
    wr(OFS_COMMAND, {4'h0, CMD_SEND_LISTEN});
    `CHK(starts, 8'h05)
    wr(OFS_COMMAND, 8'h05);
    rd(OFS_COMMAND, 8'h0C);
    wr(OFS_COMMAND, {4'h0, CMD_IDLE});
    wr(OFS_FIFO_LEVEL, 8'h80);
    for (int i = 0; i < 24; i++) wr(OFS_FIFO_DATA, 8'h10 + 8'(i));
    wr(OFS_COMMAND, {4'h0, CMD_CONFIG});
    repeat (40) @(posedge clk);
    rd(OFS_COMMAND, 8'h01);
    rd(OFS_FIFO_LEVEL, 8'h18);
    wr(OFS_FIFO_DATA, cfg[24]);
    to_idle();
    rd(OFS_FIFO_LEVEL, 8'h00);
    readback(1'b1);
    rd(OFS_CHECK_BYTE, CASCADE_TAG ^ cfg[2] ^ cfg[3] ^ cfg[4]);
    for (int i = 0; i < ID3_BYTES; i++) begin
      wr(OFS_ID3_SEL, 8'(i));
      rd(OFS_ID3_DATA, cfg[i < 3 ? i + 2 : (i < 9 ? i + 5 : 24)]);
    end
    for (int k = 1; k < 3; k++) begin
      wr(OFS_DRIVER_CTRL, 8'h03);
      repeat (2) @(posedge clk);
      `CHK(field, 1'b1)
      wr(OFS_DRIVER_CTRL, 8'(k));
      repeat (2) @(posedge clk);
      `CHK(field, 1'b0)
    end
    wr(OFS_DRIVER_CTRL, 8'h03);
    wr(OFS_COMMAND, {4'h0, CMD_SOFT_RESET});
    to_idle();
    rd(OFS_DRIVER_CTRL, 8'(DRV_CTRL_RST));
    readback(1'b1);
    wr(OFS_DRIVER_CTRL, 8'h03);
    wr(OFS_FIFO_DATA, 8'hA5);
    wr(OFS_COMMAND, 8'h17);
    rd(OFS_COMMAND, 8'h10);
    `CHK(osc, 1'b0)
    `CHK(field, 1'b1)
    rd(OFS_STATUS, 8'h05);
    wr(OFS_COMMAND, 8'h07);
    repeat (900) @(posedge clk);
    rd(OFS_COMMAND, 8'h10);
    rd(OFS_STATUS, 8'h07);
    repeat (200) @(posedge clk);
    rd(OFS_COMMAND, 8'h00);
    `CHK(osc, 1'b1)
    rd(OFS_FIFO_LEVEL, 8'h01);
    rd(OFS_FIFO_DATA, 8'hA5);
    rd(OFS_DRIVER_CTRL, 8'h03);
    pin_b <= 1'b0;
    @(posedge clk);
    pin_b <= 1'b1;
    repeat (10) @(posedge clk);
    `CHK(osc, 1'b1)
    rd(OFS_DRIVER_CTRL, 8'h03);
    pin_b <= 1'b0;
    repeat (13) @(posedge clk);
    `CHK(osc, 1'b0)
    pin_b <= 1'b1;
    rd(OFS_DRIVER_CTRL, 8'(DRV_CTRL_RST));
    `CHK(waited >= 1020, 1'b1)
    readback(1'b1);
    wr(OFS_COMMAND, {4'h0, CMD_RANDOM_ID});
    to_idle();
    readback(1'b0);
    `CHK(q != cfg[24], 1'b1)
    summarize();
  end
endmodule
`default_nettype wire
